// [verilog/fault_reaction_wake_timers.v]
`timescale 1ns/1ps
`include "fault_wake_regs.vh"
module fault_reaction_wake_timers #(
  parameter        WAKE_N        = 4,
  parameter [31:0] PERIOD_CYCLES = `PERIOD_CYCLES,
  parameter [31:0] ON_CYCLES     = `ON_CYCLES
) (
  // clock and reset
  input  wire              clk_sys,
  input  wire              rst_n,
  // avalon-mm slave
  input  wire [4:0]        address,
  input  wire              read,
  input  wire              write,
  input  wire [31:0]       writedata,
  output reg  [31:0]       readdata,
  output reg               waitrequest,
  // fault events, same clock, one-cycle pulses
  input  wire              can_fault,
  input  wire              bridge_fault,
  input  wire              hs_fault,
  input  wire              drain_source_fault,
  input  wire              regulator_uv,
  input  wire              regulator_ov,
  input  wire              regulator_short,
  input  wire              thermal_shutdown_level_two,
  input  wire              hs_overload,
  input  wire              watchdog_fail,
  input  wire              watchdog_ok,
  // wake pins, asynchronous
  input  wire [WAKE_N-1:0] wake_input,
  // host side pins
  output reg               interrupt_out_n,
  output reg               reset_out_n,
  output reg               regulator_enable,
  // fail indication
  output reg               fail_output,
  output reg               fail_or_second_wake_out,
  output reg               fail_or_second_wake_oe,
  // sensing high side
  output reg               high_side_output
);
  localparam [4:0] M_NORMAL  = 5'h01;
  localparam [4:0] M_STOP    = 5'h02;
  localparam [4:0] M_SLEEP   = 5'h04;
  localparam [4:0] M_RESTART = 5'h08;
  localparam [4:0] M_FAIL    = 5'h10;
  localparam integer RST_CYC_I = (`RESTART_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [15:0] RESTART_CYCLES = RST_CYC_I[15:0];

  reg  [4:0]        mode;
  reg  [4:0]        next_mode;
  reg  [5:0]        ctrl;
  reg  [2:0]        hs_setup;
  reg  [2:0]        per_code;
  reg  [2:0]        on_code;
  reg  [WAKE_N-1:0] wake_flag;
  reg               cwake_flag;
  reg               cmd_fail;
  reg  [3:0]        fault_flag;
  reg  [WAKE_N-1:0] level_stat;
  reg  [31:0]       irq_mask;
  reg               failure;
  reg  [2:0]        wd_count;
  reg  [2:0]        uv_count;
  reg  [15:0]       rst_cnt;
  reg  [31:0]       tcnt;
  reg               first_start;
  reg               hs_off;
  reg  [WAKE_N-1:0] last_sample;
  reg  [WAKE_N-1:0] s1;
  reg  [WAKE_N-1:0] s2;
  reg  [WAKE_N-1:0] s3;
  reg  [WAKE_N-1:0] stable;

  // an access completes in the one cycle that waitrequest is low
  wire acc   = (read | write) & ~waitrequest;
  wire wr    = write & acc;
  wire [31:0] wd = writedata;

  // timer geometry
  wire [31:0] per_len = ({29'h0, per_code} + 32'h1) * PERIOD_CYCLES;
  wire [31:0] on_len  = {29'h0, on_code} * ON_CYCLES;
  // on-time codes 0, 6 and 7 leave both timer functions stopped
  wire on_valid = (on_code != 3'h0) && (on_code != 3'h6) && (on_code != 3'h7);
  wire [31:0] wr_per = ({29'h0, wd[2:0]} + 32'h1) * PERIOD_CYCLES;
  wire [31:0] wr_on  = {29'h0, wd[6:4]} * ON_CYCLES;
  wire on_start = on_valid && (tcnt == 32'h0);
  wire on_phase = on_valid && (tcnt < on_len);
  // one sample point only, at the end of the on-time; changes after it wait a period
  wire sample   = on_valid && (tcnt == on_len - 32'h1);

  wire sensing = ctrl[`CTRL_SENSE_EN] && on_valid && (mode != M_FAIL);
  wire static_mode = ctrl[`CTRL_STATIC_EN] || (mode == M_FAIL);
  wire cwake_on = ctrl[`CTRL_CWAKE_EN] && on_valid && (mode != M_FAIL);

  // synchronised level, accepted when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < WAKE_N; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          stable[gi] <= 1'b0;
        end else if (s2[gi] == s3[gi]) begin
          stable[gi] <= s3[gi];
        end
      end
    end
  endgenerate

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= {WAKE_N{1'b0}};
      s2 <= {WAKE_N{1'b0}};
      s3 <= {WAKE_N{1'b0}};
    end else begin
      s1 <= wake_input;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // wake detection
  // cleared to the idle low level, so leaving reset makes no false edge
  reg  [WAKE_N-1:0] stable_d;
  wire [WAKE_N-1:0] static_edge = (stable ^ stable_d) & {WAKE_N{static_mode & ~sensing}};
  wire [WAKE_N-1:0] sense_chg = (stable ^ last_sample) & {WAKE_N{sensing & sample}};
  wire cwake_evt = cwake_on && on_start && !first_start;
  wire wake_evt = (|static_edge) | (|sense_chg) | cwake_evt;

  // fail-safe and restart causes
  wire active = (mode == M_NORMAL) || (mode == M_STOP);
  wire ov_fs = regulator_ov & ctrl[`CTRL_OV_FS];
  wire wd_limit = watchdog_fail && (wd_count == `FAIL_LIMIT - 3'h1);
  wire uv_limit = regulator_uv && (uv_count == `FAIL_LIMIT - 3'h1);
  // fail-safe causes outrank restart causes in normal, stop, sleep and restart
  wire go_fail = (mode != M_FAIL) &&
                 (thermal_shutdown_level_two | regulator_short | ov_fs |
                  (active & (wd_limit | uv_limit)));
  wire go_restart = active &&
                    (regulator_uv | watchdog_fail | (regulator_ov & ~ctrl[`CTRL_OV_FS]));
  wire any_src = ctrl[`CTRL_STATIC_EN] | (ctrl[`CTRL_SENSE_EN] & on_valid) | cwake_on;
  wire flags_set = (|wake_flag) | cwake_flag | fault_flag[3];
  wire mode_wr = wr && (address == `OFS_CTRL);
  wire sleep_req = mode_wr && (wd[1:0] == `REQ_SLEEP) && active;
  // pending wake or drain-source flags would wake the device at once
  wire sleep_bad = sleep_req && ((mode == M_STOP) || !any_src || flags_set);

  always @* begin
    next_mode = mode;
    case (mode)
      M_NORMAL, M_STOP: begin
        if (go_fail) begin
          next_mode = M_FAIL;
        end else if (go_restart || sleep_bad) begin
          next_mode = M_RESTART;
        end else if (sleep_req) begin
          next_mode = M_SLEEP;
        end else if (mode_wr && wd[1:0] == `REQ_STOP) begin
          next_mode = M_STOP;
        end else if (mode_wr && wd[1:0] == `REQ_NORMAL) begin
          next_mode = M_NORMAL;
        end
      end
      M_SLEEP: begin
        if (go_fail) begin
          next_mode = M_FAIL;
        end else if (wake_evt || regulator_uv || regulator_ov) begin
          next_mode = M_RESTART;
        end
      end
      // reset stays asserted for the whole restart count
      M_RESTART: begin
        if (go_fail) begin
          next_mode = M_FAIL;
        end else if (rst_cnt == RESTART_CYCLES - 16'h1) begin
          next_mode = M_NORMAL;
        end
      end
      M_FAIL: begin
        // a thermal shutdown seen in the same cycle keeps fail-safe
        if (wake_evt && !thermal_shutdown_level_two) begin
          next_mode = M_RESTART;
        end
      end
      default: next_mode = M_RESTART;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode    <= M_RESTART;
      rst_cnt <= 16'h0;
      failure <= 1'b0;
    end else begin
      mode <= next_mode;
      if (mode == M_RESTART && next_mode == M_RESTART) begin
        rst_cnt <= rst_cnt + 16'h1;
      end else begin
        rst_cnt <= 16'h0;
      end
      if (mode == M_FAIL && next_mode != M_FAIL) begin
        failure <= 1'b1;
      end else if (wr && address == `OFS_DEV_STATE && wd[`DEV_FAILURE]) begin
        failure <= 1'b0;
      end
    end
  end

  // consecutive counters; a good watchdog trigger proves a healthy run
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wd_count <= 3'h0;
      uv_count <= 3'h0;
    end else if (next_mode == M_FAIL) begin
      wd_count <= 3'h0;
      uv_count <= 3'h0;
    end else begin
      if (watchdog_fail && active) begin
        wd_count <= wd_count + 3'h1;
      end else if (watchdog_ok) begin
        wd_count <= 3'h0;
      end
      if (regulator_uv && active) begin
        uv_count <= uv_count + 3'h1;
      end else if (watchdog_ok) begin
        uv_count <= 3'h0;
      end
    end
  end

  // timer and high side
  // dropping the on code on fail-safe entry stops both timer functions
  wire fail_entry = (next_mode == M_FAIL) && (mode != M_FAIL);
  wire timer_wr = wr && (address == `OFS_TIMER);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tcnt             <= 32'h0;
      first_start      <= 1'b1;
      hs_off           <= 1'b0;
      last_sample      <= {WAKE_N{1'b0}};
      stable_d         <= {WAKE_N{1'b0}};
      high_side_output <= 1'b0;
    end else begin
      stable_d <= stable;
      // a timer write restarts the count and re-arms the first-start skip
      if (timer_wr || !on_valid) begin
        tcnt        <= 32'h0;
        first_start <= 1'b1;
      end else begin
        tcnt <= (tcnt >= per_len - 32'h1) ? 32'h0 : tcnt + 32'h1;
        if (on_start) begin
          first_start <= 1'b0;
        end
      end
      // a disabled switch stays off until the host rewrites the timer
      if (fail_entry) begin
        hs_off <= 1'b1;
      end else if ((mode != M_FAIL) && (hs_overload | regulator_uv | regulator_ov)) begin
        hs_off <= 1'b1;
      end else if (timer_wr) begin
        hs_off <= 1'b0;
      end
      // the reference level follows a timer write, so starting cannot wake
      if (timer_wr) begin
        last_sample <= stable;
      end else if (sensing && sample) begin
        last_sample <= stable;
      end
      if (hs_off || mode == M_FAIL) begin
        high_side_output <= 1'b0;
      end else if (sensing && hs_setup[`HS_MAP_TIMER]) begin
        high_side_output <= on_phase ? 1'b1 : hs_setup[`HS_INIT_HIGH];
      end else begin
        high_side_output <= hs_setup[`HS_INIT_HIGH];
      end
    end
  end

  // register writes; hardware set wins over software clear
  wire wake_clr  = wr && (address == `OFS_WAKE_STAT);
  wire fault_clr = wr && (address == `OFS_FAULT_STAT);
  // these faults only flag and interrupt; the mode is left alone
  wire [3:0] fault_set = {drain_source_fault, hs_fault, bridge_fault, can_fault};
  wire cmd_bad = timer_wr && (wr_on > wr_per);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl       <= 6'h0;
      hs_setup   <= 3'h0;
      per_code   <= 3'h0;
      on_code    <= 3'h0;
      wake_flag  <= {WAKE_N{1'b0}};
      cwake_flag <= 1'b0;
      cmd_fail   <= 1'b0;
      fault_flag <= 4'h0;
      level_stat <= {WAKE_N{1'b0}};
      irq_mask   <= `MASK_RESET;
    end else begin
      if (mode_wr) begin
        ctrl <= wd[5:0];
      end
      if (wr && address == `OFS_HS_SETUP) begin
        hs_setup <= wd[2:0];
      end
      if (fail_entry) begin
        on_code <= 3'h0;
      end else if (timer_wr) begin
        per_code <= wd[2:0];
        on_code  <= wd[6:4];
      end
      if (wr && address == `OFS_IRQ_MASK) begin
        irq_mask <= wd;
      end
      wake_flag <= (wake_flag & ~({WAKE_N{wake_clr}} & wd[WAKE_N-1:0]))
                   | static_edge | sense_chg;
      cwake_flag <= (cwake_flag & ~(wake_clr & wd[`WS_CWAKE])) | cwake_evt;
      // a sleep request refused in stop mode or with no wake source counts as a command failure too
      cmd_fail <= (cmd_fail & ~(wake_clr & wd[`WS_CMD_FAIL])) | cmd_bad
                  | (sleep_req & (mode == M_STOP | ~any_src));
      fault_flag <= (fault_flag & ~({4{fault_clr}} & wd[3:0])) | fault_set;
      // outside active sensing the level register follows the pins
      if (sensing && active) begin
        if (sample) begin
          level_stat <= stable;
        end
      end else begin
        level_stat <= stable;
      end
    end
  end

  // pins and bus
  wire [31:0] irq_src = {22'h0, cmd_fail, cwake_flag, fault_flag, wake_flag};
  wire fail_active = (mode == M_FAIL) || failure;
  // judged on the mode being entered, so it never falls while reset goes low
  wire next_active = (next_mode == M_NORMAL) || (next_mode == M_STOP);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest             <= 1'b1;
      readdata                <= 32'h0;
      interrupt_out_n         <= 1'b1;
      reset_out_n             <= 1'b0;
      regulator_enable        <= 1'b1;
      fail_output             <= 1'b0;
      fail_or_second_wake_out <= 1'b0;
      fail_or_second_wake_oe  <= 1'b0;
    end else begin
      // exactly one wait state, then high again for one idle cycle
      waitrequest <= ~((read | write) & waitrequest);
      // read data is launched with the wait state so it stands while waitrequest is low
      if (read & waitrequest) begin
        case (address)
          `OFS_CTRL:       readdata <= {26'h0, ctrl};
          `OFS_DEV_STATE:  readdata <= {17'h0, uv_count, wd_count, failure, 3'h0, mode};
          `OFS_HS_SETUP:   readdata <= {29'h0, hs_setup};
          `OFS_TIMER:      readdata <= {25'h0, on_code, 1'b0, per_code};
          `OFS_WAKE_STAT:  readdata <= {22'h0, cmd_fail, cwake_flag, 4'h0, wake_flag};
          `OFS_FAULT_STAT: readdata <= {28'h0, fault_flag};
          `OFS_WAKE_LEVEL: readdata <= {28'h0, level_stat};
          `OFS_IRQ_MASK:   readdata <= irq_mask;
          default:         readdata <= 32'h0;
        endcase
      end
      // interrupt only reaches a running host
      interrupt_out_n <= ~(next_active && |(irq_src & irq_mask));
      // reset and regulator pins follow next_mode so they switch together with the mode register
      reset_out_n <= ~((next_mode == M_RESTART) || (next_mode == M_FAIL));
      regulator_enable <= (next_mode != M_SLEEP) && (next_mode != M_FAIL);
      fail_output <= fail_active;
      fail_or_second_wake_out <= 1'b0;
      fail_or_second_wake_oe  <= fail_active & hs_setup[`HS_PIN_IS_FAIL];
    end
  end
endmodule

// [verilog/fault_wake_regs.vh]
`ifndef FAULT_WAKE_REGS_VH
`define FAULT_WAKE_REGS_VH

`define OFS_CTRL        5'h00
`define OFS_DEV_STATE   5'h04
`define OFS_HS_SETUP    5'h08
`define OFS_TIMER       5'h0C
`define OFS_WAKE_STAT   5'h10
`define OFS_FAULT_STAT  5'h14
`define OFS_WAKE_LEVEL  5'h18
`define OFS_IRQ_MASK    5'h1C

`define CTRL_OV_FS      2
`define CTRL_STATIC_EN  3
`define CTRL_SENSE_EN   4
`define CTRL_CWAKE_EN   5
`define HS_INIT_HIGH    0
`define HS_MAP_TIMER    1
`define HS_PIN_IS_FAIL  2
`define WS_CWAKE        8
`define WS_CMD_FAIL     9
`define DEV_FAILURE     8

`define REQ_NORMAL      2'h1
`define REQ_STOP        2'h2
`define REQ_SLEEP       2'h3

`define FAIL_LIMIT      3'h4
`define RESTART_NS      10000
`define CLK_NS          10
`define PERIOD_CYCLES   1000000
`define ON_CYCLES       10000
`define MASK_RESET      32'h0000_03FF
`endif

// [bench/fault_reaction_wake_timers_props.sv]
`timescale 1ns/1ps
module fault_reaction_wake_timers_props #(
  parameter        WAKE_N        = 4,
  parameter [31:0] PERIOD_CYCLES = 32'h000F_4240,
  parameter [31:0] ON_CYCLES     = 32'h0000_2710
) (
  // clock, reset and bus handshake
  input wire clk_sys,
  input wire rst_n,
  input wire read,
  input wire write,
  input wire waitrequest,
  // events
  input wire regulator_uv,
  input wire watchdog_fail,
  input wire thermal_shutdown_level_two,
  input wire hs_overload,
  // pins
  input wire interrupt_out_n,
  input wire reset_out_n,
  input wire regulator_enable,
  input wire fail_output,
  input wire fail_or_second_wake_out,
  input wire fail_or_second_wake_oe,
  input wire high_side_output
);
  // cycles spent with the reset output low since it last went high
  reg [31:0] low_cnt;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) low_cnt <= 32'h0;
    else low_cnt <= reset_out_n ? 32'h0 : low_cnt + 32'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus access not answered after one cycle");
  chk_uv_restart: assert property (regulator_uv && reset_out_n && regulator_enable |-> ##[1:2] !reset_out_n)
    else $error("undervoltage did not pull the reset output low");
  chk_wd_restart: assert property (watchdog_fail && reset_out_n && regulator_enable |-> ##[1:2] !reset_out_n)
    else $error("watchdog failure did not pull the reset output low");
  chk_tsd_failsafe: assert property (thermal_shutdown_level_two |-> ##[1:2] (fail_output && !regulator_enable))
    else $error("thermal shutdown did not reach fail-safe");
  // restart is 1000 cycles; two cycles of slack for pin latency
  chk_restart_length: assert property ($rose(reset_out_n) |-> low_cnt >= 32'h0000_03E6)
    else $error("reset output released too early");
  chk_failsafe_hs: assert property (!regulator_enable && !reset_out_n |=> !high_side_output)
    else $error("high side on in fail-safe");
  chk_fail_pin: assert property (fail_or_second_wake_oe |-> fail_output && !fail_or_second_wake_out)
    else $error("shared pin driven without fail indication");
  chk_overload_hs: assert property (hs_overload |-> ##2 (!high_side_output) [*4])
    else $error("high side still on after overload");
  chk_irq_mode: assert property ($fell(interrupt_out_n) |-> reset_out_n && regulator_enable)
    else $error("interrupt raised outside normal or stop");
endmodule

bind fault_reaction_wake_timers fault_reaction_wake_timers_props #(
  .WAKE_N(WAKE_N), .PERIOD_CYCLES(PERIOD_CYCLES), .ON_CYCLES(ON_CYCLES)
) props_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .read(read), .write(write), .waitrequest(waitrequest),
  .regulator_uv(regulator_uv), .watchdog_fail(watchdog_fail), .hs_overload(hs_overload),
  .thermal_shutdown_level_two(thermal_shutdown_level_two), .interrupt_out_n(interrupt_out_n),
  .reset_out_n(reset_out_n), .regulator_enable(regulator_enable), .fail_output(fail_output),
  .fail_or_second_wake_out(fail_or_second_wake_out),
  .fail_or_second_wake_oe(fail_or_second_wake_oe), .high_side_output(high_side_output)
);

// [bench/wake_switch_net.sv]
`timescale 1ns/1ps
module wake_switch_net #(
  parameter W = 4
) (
  // switch states and supply source
  input  wire [W-1:0] sw_closed,
  input  wire         hs_on,
  input  wire         hs_fed,
  // towards the wake inputs
  output wire [W-1:0] level
);
  // an unpowered network falls to its pull-down instead of keeping the last level
  assign level = (!hs_fed || hs_on) ? sw_closed : {W{1'h0}};
endmodule

// [bench/fault_reaction_wake_timers_tb.sv]
`timescale 1ns/1ps
module fault_reaction_wake_timers_tb;
  reg         clk_sys     = 1'h0;
  reg         rst_n       = 1'h0;
  reg  [4:0]  address     = 5'h00;
  reg         read        = 1'h0;
  reg         write       = 1'h0;
  reg  [31:0] writedata   = 32'h0;
  reg  [10:0] ev          = 11'h000;
  reg  [3:0]  sw          = 4'h0;
  reg         hs_fed      = 1'h0;
  reg  [31:0] d;
  integer     error_cnt   = 0;
  integer     checks_done = 0;
  integer     cyc         = 0;
  integer     k;
  wire [31:0] readdata;
  wire [3:0]  wake_input;
  wire        waitrequest, interrupt_out_n, reset_out_n, regulator_enable, fail_output;
  wire        fail_or_second_wake_out, fail_or_second_wake_oe, high_side_output;
  always #5 clk_sys = ~clk_sys;
  fault_reaction_wake_timers #(.WAKE_N(4), .PERIOD_CYCLES(32'h28), .ON_CYCLES(32'hA)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .can_fault(ev[0]), .bridge_fault(ev[1]), .hs_fault(ev[2]), .drain_source_fault(ev[3]),
    .regulator_uv(ev[4]), .regulator_ov(ev[5]), .regulator_short(ev[6]),
    .thermal_shutdown_level_two(ev[7]), .hs_overload(ev[8]), .watchdog_fail(ev[9]),
    .watchdog_ok(ev[10]), .wake_input(wake_input), .interrupt_out_n(interrupt_out_n),
    .reset_out_n(reset_out_n), .regulator_enable(regulator_enable), .fail_output(fail_output),
    .fail_or_second_wake_out(fail_or_second_wake_out),
    .fail_or_second_wake_oe(fail_or_second_wake_oe), .high_side_output(high_side_output));
  wake_switch_net #(.W(4)) net_u (.sw_closed(sw), .hs_on(high_side_output), .hs_fed(hs_fed),
    .level(wake_input));
  task chk(input [31:0] seen, input [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one access; the next call may start at once since we leave on an idle edge
  task bus(input wr, input [4:0] a, input [31:0] wd);
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    @(posedge clk_sys);
    while (waitrequest !== 1'h0) @(posedge clk_sys);
    d = readdata;
    read <= 1'h0;
    write <= 1'h0;
    @(posedge clk_sys);
  endtask
  task pulse(input integer i);
    ev[i] <= 1'h1;
    @(posedge clk_sys);
    ev <= 11'h000;
    repeat (2) @(posedge clk_sys);
  endtask
  task wait_up;
    @(posedge clk_sys);
    while (reset_out_n !== 1'h1) @(posedge clk_sys);
  endtask
  task mode_is(input [4:0] m);
    bus(1'h0, 5'h04, 32'h0);
    chk(d[4:0], m);
  endtask
  // in fail-safe: check pins, leave by a static wake edge, then release the fail output
  task fs_exit(input oe_exp);
    mode_is(5'h10);
    chk(fail_or_second_wake_oe, oe_exp);
    chk(high_side_output, 1'h0);
    sw <= ~sw;
    wait_up;
    bus(1'h0, 5'h04, 32'h0);
    chk({d[8], fail_output}, 2'h3);
    bus(1'h1, 5'h04, 32'h0000_0100);
    @(posedge clk_sys);
    chk(fail_output, 1'h0);
    bus(1'h1, 5'h10, 32'hFFFF_FFFF);
  endtask
  task results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      results;
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    chk(reset_out_n, 1'h0);
    mode_is(5'h08);
    wait_up;
    mode_is(5'h01);
    bus(1'h0, 5'h1C, 32'h0);
    chk(d, 32'h0000_03FF);
    bus(1'h1, 5'h1E, 32'hFFFF_FFFF);
    bus(1'h0, 5'h1E, 32'h0);
    chk(d, 32'h0);
    for (k = 0; k < 3; k = k + 1) pulse(k);
    bus(1'h0, 5'h14, 32'h0);
    chk(d[3:0], 4'h7);
    chk(interrupt_out_n, 1'h0);
    mode_is(5'h01);
    for (k = 0; k < 3; k = k + 1) begin
      pulse(k == 0 ? 4 : k == 1 ? 9 : 5);
      mode_is(5'h08);
      wait_up;
      pulse(10);
    end
    bus(1'h1, 5'h08, 32'h4);
    for (k = 0; k < 2; k = k + 1) begin
      repeat (3) begin
        pulse(k ? 4 : 9);
        wait_up;
      end
      pulse(k ? 4 : 9);
      fs_exit(k == 0);
      bus(1'h1, 5'h08, 32'h0);
    end
    bus(1'h1, 5'h00, 32'h4);
    for (k = 5; k < 8; k = k + 1) begin
      pulse(k);
      fs_exit(1'h0);
    end
    bus(1'h1, 5'h00, 32'h3);
    mode_is(5'h08);
    wait_up;
    bus(1'h1, 5'h00, 32'h8);
    sw <= ~sw;
    repeat (8) @(posedge clk_sys);
    bus(1'h0, 5'h10, 32'h0);
    chk(d[3:0], 4'hF);
    bus(1'h1, 5'h00, 32'hB);
    mode_is(5'h08);
    wait_up;
    bus(1'h1, 5'h00, 32'h10);
    bus(1'h1, 5'h08, 32'h2);
    bus(1'h1, 5'h10, 32'hFFFF_FFFF);
    bus(1'h1, 5'h0C, 32'h50);
    bus(1'h0, 5'h10, 32'h0);
    chk(d[9], 1'h1);
    hs_fed <= 1'h1;
    bus(1'h1, 5'h0C, 32'h10);
    bus(1'h1, 5'h14, 32'hFFFF_FFFF);
    bus(1'h1, 5'h10, 32'hFFFF_FFFF);
    repeat (100) @(posedge clk_sys);
    chk(interrupt_out_n, 1'h1);
    sw <= sw ^ 4'h1;
    repeat (100) @(posedge clk_sys);
    bus(1'h0, 5'h10, 32'h0);
    chk(d[3:0], 4'h1);
    chk(interrupt_out_n, 1'h0);
    for (k = 0; k < 4; k = k + 1) begin
      bus(1'h0, 5'h18, 32'h0);
      chk(d[3:0], sw);
    end
    pulse(8);
    for (k = 0; k < 40; k = k + 1) begin
      @(posedge clk_sys);
      chk(high_side_output, 1'h0);
    end
    bus(1'h1, 5'h00, 32'h20);
    for (k = 0; k < 4; k = k + 1) begin
      bus(1'h1, 5'h10, 32'hFFFF_FFFF);
      bus(1'h1, 5'h0C, {25'h0, ((k == 0) ? 3'h0 : (k == 3) ? 3'h2 : 3'h5 + k[2:0]), 4'h0});
      bus(1'h0, 5'h10, 32'h0);
      chk(d[8], 1'h0);
      repeat (100) @(posedge clk_sys);
      bus(1'h0, 5'h10, 32'h0);
      chk(d[8], k == 3);
    end
    chk(interrupt_out_n, 1'h0);
    // restart the timer so no cyclic wake lands before the sleep request
    bus(1'h1, 5'h0C, 32'h20);
    bus(1'h1, 5'h10, 32'hFFFF_FFFF);
    bus(1'h1, 5'h00, 32'h23);
    mode_is(5'h04);
    chk(regulator_enable, 1'h0);
    repeat (60) @(posedge clk_sys);
    mode_is(5'h08);
    chk(reset_out_n, 1'h0);
    wait_up;
    mode_is(5'h01);
    results;
  end
endmodule
